/* File: fpll_consts.svh */
// Constants for the fractional divider and calibration timing block.
`ifndef FPLL_CONSTS_SVH
`define FPLL_CONSTS_SVH
`define FPLL_ADDR_INT        4'h0
`define FPLL_ADDR_PFRAC      4'h1
`define FPLL_ADDR_AFRAC      4'h2
`define FPLL_ADDR_AMOD       4'h3
`define FPLL_ADDR_REFCTL     4'h4
`define FPLL_ADDR_TIMING     4'h5
`define FPLL_ADDR_CALCTL     4'h6
`define FPLL_ADDR_STATUS     4'h7
`define FPLL_ADDR_NSTEP      4'h8
`define FPLL_INT_RST         16'h0017
`define FPLL_AMOD_RST        14'h0002
`define FPLL_R_RST           10'h001
`define FPLL_TIMEOUT_RST     10'h067
`define FPLL_LOCKTO_RST      5'h0C
`define FPLL_BANDDIV_RST     8'h1A
`define FPLL_BAND_CYCLES     4'hB
`define FPLL_BAND_PRESCALE   4'hF
`define FPLL_PMOD_BITS       24
`endif

/* File: fpll_pkg.sv */
// Types shared by the fractional divider and calibration timing block.
package fpll_pkg;
  typedef enum logic [3:0]
  {
    FPLL_IDLE   = 4'h1,
    FPLL_SETTLE = 4'h2,
    FPLL_BAND   = 4'h4,
    FPLL_DONE   = 4'h8
  } fpll_cal_type;
endpackage

/* File: fpll_ref_div.sv */
// Reference path: R divider and divide-by-two halving stage; the doubler input is not used.
`timescale 1ns/10ps
`default_nettype none
module fpll_ref_div
#(
  parameter int R_W = 10
)
(
  input  wire logic           clk_in,
  input  wire logic           nrst_in,
  input  wire logic           ref_edge_in,
  input  wire logic           doubler_in,
  input  wire logic [R_W-1:0] r_div_in,
  input  wire logic           halve_in,
  output logic                pfd_tick_out
);
  typedef struct packed
  {
    logic [R_W-1:0] rcnt;
    logic           half;
    logic           tick;
  } fpll_rd_type;
  fpll_rd_type st_r;
  fpll_rd_type st_nxt;
  logic        ref_tick;
  logic [R_W-1:0] r_eff;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    r_eff = (r_div_in == '0) ? R_W'(1) : r_div_in;
    // The doubler setting is ignored: every reference edge pulse counts, with or without it.
    ref_tick = ref_edge_in;
    if (ref_tick)
    begin
      if (st_r.rcnt + R_W'(1) >= r_eff)
      begin
        st_nxt.rcnt = '0;
        if (halve_in)
        begin
          // The halving toggle passes every second terminal count as a one-cycle tick, halving the tick rate.
          st_nxt.half = ~st_r.half;
          st_nxt.tick = st_r.half;
        end
        else
        begin
          st_nxt.tick = 1'b1;
        end
      end
      else
      begin
        st_nxt.rcnt = st_r.rcnt + R_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pfd_tick_out = st_r.tick;
endmodule
`default_nettype wire

/* File: fpll_core.sv */
// Top of the fractional divider and calibration timing block.
`timescale 1ns/10ps
`default_nettype none
`include "fpll_consts.svh"
module fpll_core
#(
  parameter int R_W = 10
)
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        ref_edge_in,
  input  wire logic        vco_tick_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  output logic             pfd_tick_out,
  output logic             fb_tick_out,
  output logic             cal_busy_out,
  output logic             band_sel_out,
  output logic             cal_done_out
);
  typedef struct packed
  {
    logic [15:0]            int_part;
    logic [23:0]            primary_fraction;
    logic [13:0]            auxiliary_fraction;
    logic [13:0]            auxiliary_modulus;
    logic                   doubler;
    logic                   halve;
    logic [R_W-1:0]         r_div;
    logic [9:0]             timeout;
    logic [4:0]             lock_timeout;
    logic [4:0]             level_cal_wait;
    logic [7:0]             band_division_value;
    fpll_pkg::fpll_cal_type cal;
    logic [14:0]            settle_cnt;
    logic [11:0]            pre_cnt;
    logic [3:0]             band_cnt;
    logic [15:0]            n_cnt;
    logic [23:0]            acc1;
    logic [13:0]            acc2;
    logic                   carry_hold;
    logic [31:0]            rdata;
    logic                   fb_tick;
    logic                   pfd_tick;
    logic                   busy;
    logic                   band;
    logic                   done;
  } fpll_core_type;
  fpll_core_type st_r;
  fpll_core_type st_nxt;
  logic          pfd_tick;
  logic [24:0]   sum1;
  logic [14:0]   sum2;
  logic          aux_carry;

  fpll_ref_div #(.R_W(R_W)) u_ref
  (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .ref_edge_in  (ref_edge_in),
    .doubler_in   (st_r.doubler),
    .r_div_in     (st_r.r_div),
    .halve_in     (st_r.halve),
    .pfd_tick_out (pfd_tick)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.fb_tick = 1'b0;
    st_nxt.pfd_tick = pfd_tick;
    sum2 = '0;
    sum1 = '0;
    aux_carry = 1'b0;
    // Register writes.
    if (wr_in)
    begin
      if (addr_in == `FPLL_ADDR_INT)
      begin
        st_nxt.int_part = wdata_in[15:0];
      end
      else if (addr_in == `FPLL_ADDR_PFRAC)
      begin
        st_nxt.primary_fraction = wdata_in[23:0];
      end
      else if (addr_in == `FPLL_ADDR_AFRAC)
      begin
        st_nxt.auxiliary_fraction = wdata_in[13:0];
      end
      else if (addr_in == `FPLL_ADDR_AMOD)
      begin
        st_nxt.auxiliary_modulus = wdata_in[13:0];
      end
      else if (addr_in == `FPLL_ADDR_REFCTL)
      begin
        st_nxt.r_div = wdata_in[R_W-1:0];
        st_nxt.doubler = wdata_in[16];
        st_nxt.halve = wdata_in[17];
      end
      else if (addr_in == `FPLL_ADDR_TIMING)
      begin
        st_nxt.timeout = wdata_in[23:14];
        st_nxt.level_cal_wait = wdata_in[13:9];
        st_nxt.lock_timeout = wdata_in[8:4];
        st_nxt.band_division_value = wdata_in[31:24];
      end
      else if (addr_in == `FPLL_ADDR_CALCTL && wdata_in[0] && st_r.cal != fpll_pkg::FPLL_SETTLE
               && st_r.cal != fpll_pkg::FPLL_BAND)
      begin
        st_nxt.cal = fpll_pkg::FPLL_SETTLE;
        st_nxt.settle_cnt = 15'(st_r.timeout * st_r.lock_timeout);
        st_nxt.pre_cnt = '0;
        st_nxt.band_cnt = '0;
      end
    end
    // Fractional-N feedback divider clocked by the oscillator ticks on vco_tick_in.
    if (vco_tick_in)
    begin
      if (st_r.n_cnt == 16'h0000)
      begin
        st_nxt.fb_tick = 1'b1;
        sum2 = {1'b0, st_r.acc2} + {1'b0, st_r.auxiliary_fraction};
        if (sum2 >= {1'b0, st_r.auxiliary_modulus} && st_r.auxiliary_modulus != '0)
        begin
          aux_carry = 1'b1;
          sum2 = sum2 - {1'b0, st_r.auxiliary_modulus};
        end
        st_nxt.acc2 = sum2[13:0];
        // Primary accumulator wraps at the fixed 24-bit modulus.
        sum1 = {1'b0, st_r.acc1} + {1'b0, st_r.primary_fraction} + 25'(aux_carry);
        st_nxt.acc1 = sum1[`FPLL_PMOD_BITS-1:0];
        st_nxt.carry_hold = sum1[`FPLL_PMOD_BITS];
        st_nxt.n_cnt = sum1[`FPLL_PMOD_BITS] ? st_r.int_part : st_r.int_part - 16'h0001;
      end
      else
      begin
        st_nxt.n_cnt = st_r.n_cnt - 16'h0001;
      end
    end
    // Calibration timing runs on phase detector ticks.
    case (st_r.cal)
      fpll_pkg::FPLL_SETTLE:
      begin
        if (pfd_tick)
        begin
          if (st_r.settle_cnt <= 15'h0001)
          begin
            st_nxt.cal = fpll_pkg::FPLL_BAND;
          end
          else
          begin
            st_nxt.settle_cnt = st_r.settle_cnt - 15'h0001;
          end
        end
      end
      fpll_pkg::FPLL_BAND:
      begin
        if (pfd_tick)
        begin
          // One band clock spans sixteen times the division value in phase detector ticks.
          if (st_r.pre_cnt >= {st_r.band_division_value - 8'h01, `FPLL_BAND_PRESCALE} ||
              st_r.band_division_value == 8'h00)
          begin
            st_nxt.pre_cnt = '0;
            if (st_r.band_cnt == `FPLL_BAND_CYCLES - 4'h1)
            begin
              st_nxt.cal = fpll_pkg::FPLL_DONE;
            end
            else
            begin
              st_nxt.band_cnt = st_r.band_cnt + 4'h1;
            end
          end
          else
          begin
            st_nxt.pre_cnt = st_r.pre_cnt + 12'h001;
          end
        end
      end
      default:
      begin
      end
    endcase
    // Phase flags are registered so that the outputs come straight from flip-flops.
    st_nxt.busy = (st_nxt.cal == fpll_pkg::FPLL_SETTLE) || (st_nxt.cal == fpll_pkg::FPLL_BAND);
    st_nxt.band = st_nxt.cal == fpll_pkg::FPLL_BAND;
    st_nxt.done = st_nxt.cal == fpll_pkg::FPLL_DONE;
    // Register reads, data in the following cycle.
    st_nxt.rdata = '0;
    if (rd_in)
    begin
      if (addr_in == `FPLL_ADDR_INT)
      begin
        st_nxt.rdata = {16'h0000, st_r.int_part};
      end
      else if (addr_in == `FPLL_ADDR_PFRAC)
      begin
        st_nxt.rdata = {8'h00, st_r.primary_fraction};
      end
      else if (addr_in == `FPLL_ADDR_AFRAC)
      begin
        st_nxt.rdata = {18'h00000, st_r.auxiliary_fraction};
      end
      else if (addr_in == `FPLL_ADDR_AMOD)
      begin
        st_nxt.rdata = {18'h00000, st_r.auxiliary_modulus};
      end
      else if (addr_in == `FPLL_ADDR_REFCTL)
      begin
        st_nxt.rdata = {14'h0000, st_r.halve, st_r.doubler, 16'(st_r.r_div)};
      end
      else if (addr_in == `FPLL_ADDR_TIMING)
      begin
        st_nxt.rdata = {st_r.band_division_value, st_r.timeout, st_r.level_cal_wait, st_r.lock_timeout, 4'h0};
      end
      else if (addr_in == `FPLL_ADDR_STATUS)
      begin
        st_nxt.rdata = {28'h0000000, st_r.cal};
      end
      else if (addr_in == `FPLL_ADDR_NSTEP)
      begin
        st_nxt.rdata = {15'h0000, st_r.carry_hold, st_r.n_cnt};
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      st_r <= '0;
      st_r.int_part <= `FPLL_INT_RST;
      st_r.auxiliary_modulus <= `FPLL_AMOD_RST;
      st_r.r_div <= R_W'(`FPLL_R_RST);
      st_r.timeout <= `FPLL_TIMEOUT_RST;
      st_r.lock_timeout <= `FPLL_LOCKTO_RST;
      st_r.band_division_value <= `FPLL_BANDDIV_RST;
      st_r.cal <= fpll_pkg::FPLL_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign pfd_tick_out = st_r.pfd_tick;
  assign fb_tick_out = st_r.fb_tick;
  assign cal_busy_out = st_r.busy;
  assign band_sel_out = st_r.band;
  assign cal_done_out = st_r.done;
endmodule
`default_nettype wire

/* File: fpll_src_model.sv */
// Reference and oscillator edge source standing in for the analog side.
`timescale 1ns/10ps
`default_nettype none
module fpll_src_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] ref_per_in,
  input  wire logic [7:0] vco_per_in,
  output logic            ref_edge_out,
  output logic            vco_tick_out
);
  int rc = 0;
  int vc = 0;
  initial
  begin
    ref_edge_out = 1'b0;
    vco_tick_out = 1'b0;
  end
  // A period of one gives an edge every cycle; larger periods answer slowly.
  always @(posedge clk_in)
  begin
    rc <= (rc + 1 >= ref_per_in) ? 0 : rc + 1;
    vc <= (vc + 1 >= vco_per_in) ? 0 : vc + 1;
    ref_edge_out <= (rc + 1 >= ref_per_in);
    vco_tick_out <= (vc + 1 >= vco_per_in);
  end
endmodule
`default_nettype wire

/* File: fpll_core_props.sv */
// Checker for the fractional divider and calibration timing block.
`timescale 1ns/10ps
`default_nettype none
module fpll_core_props
(
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [3:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        cal_busy_out,
  input wire logic        band_sel_out,
  input wire logic        cal_done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  rd_quiet_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("Read data not zero outside the answer cycle.");
  status_code_a: assert property ($past(rd_in) && $past(addr_in) == 4'h7 |-> rdata_out == {28'h0,
    $past(cal_done_out), $past(band_sel_out), $past(cal_busy_out) && !$past(band_sel_out),
    !$past(cal_busy_out) && !$past(cal_done_out)}) else $error("Status code does not match phase.");
  band_in_busy_a: assert property (band_sel_out |-> cal_busy_out)
    else $error("Band selection outside busy.");
  done_idle_a: assert property (cal_done_out |-> !cal_busy_out)
    else $error("Done while busy.");
  band_entry_a: assert property ($rose(band_sel_out) |-> $past(cal_busy_out))
    else $error("Band selection without settle phase.");
  done_entry_a: assert property ($rose(cal_done_out) |-> $past(band_sel_out))
    else $error("Done without band selection.");
  start_settle_a: assert property (wr_in && addr_in == 4'h6 && wdata_in[0] && !cal_busy_out
    |=> cal_busy_out && !band_sel_out) else $error("Start did not enter settle.");
  band_min_a: assert property ($rose(band_sel_out) |-> band_sel_out[*8])
    else $error("Band selection too short.");
  done_hold_a: assert property (cal_done_out && !(wr_in && addr_in == 4'h6 && wdata_in[0]) |=> cal_done_out)
    else $error("Done dropped without a new start.");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the fractional divider and calibration timing block.
`timescale 1ns/10ps
`default_nettype none
`include "fpll_consts.svh"
module tb_top;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  per = 8'h01;
  logic        ref_edge, vco_tick, pfd_tick, fb_tick, busy, band, done;
  logic [31:0] rdata, v;
  logic [31:0] msk [4] = '{32'hFFFF, 32'hFFFFFF, 32'h3FFF, 32'h3FFF};
  int          miscompares = 0;
  int          checked = 0;
  int          seed = 32'h24f4;
  int          n_set = 0;
  int          n_band = 0;
  int          c, r, h;
  always #10 clk_in = ~clk_in;
  fpll_src_model fpll_src_model_inst (.clk_in(clk_in), .ref_per_in(per), .vco_per_in(per),
    .ref_edge_out(ref_edge), .vco_tick_out(vco_tick));
  fpll_core fpll_core_inst (.clk_in(clk_in), .nrst_in(nrst_in), .ref_edge_in(ref_edge), .vco_tick_in(vco_tick),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pfd_tick_out(pfd_tick),
    .fb_tick_out(fb_tick), .cal_busy_out(busy), .band_sel_out(band), .cal_done_out(done));
  always @(posedge clk_in)
  begin
    if (busy && !band)
      n_set++;
    if (band)
      n_band++;
  end
  task results;
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk(nm, rdata & m, e & m);
  endtask
  // Counts clock cycles from one pulse to the n-th pulse after it.
  task automatic span(input bit fb, input int n, output int cy);
    int k;
    k = 0;
    cy = 0;
    while (k <= n)
    begin
      @(posedge clk_in);
      #1;
      if (k > 0)
        cy++;
      if ((fb ? fb_tick : pfd_tick) === 1'b1)
        k++;
      if (cy > 4000)
      begin
        miscompares++;
        results();
      end
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_reg(`FPLL_ADDR_STATUS, 32'hFFFFFFFF, {28'h0, fpll_pkg::FPLL_IDLE}, "status");
    rd_reg(`FPLL_ADDR_INT, 32'hFFFFFFFF, {16'h0, `FPLL_INT_RST}, "int");
    rd_reg(`FPLL_ADDR_AMOD, 32'hFFFFFFFF, {18'h0, `FPLL_AMOD_RST}, "aux_modulus");
    rd_reg(`FPLL_ADDR_REFCTL, 32'hFFFFFFFF, {22'h0, `FPLL_R_RST}, "refctl");
    rd_reg(`FPLL_ADDR_TIMING, 32'hFFFFC1F0, {`FPLL_BANDDIV_RST, `FPLL_TIMEOUT_RST, 5'h0, `FPLL_LOCKTO_RST, 4'h0},
      "timing");
    rd_reg(4'h9, 32'hFFFFFFFF, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      wr_reg(i[3:0], v);
      rd_reg(i[3:0], 32'hFFFFFFFF, v & msk[i], "field");
    end
    for (h = 0; h < 2; h++)
    begin
      r = 1 + ($unsigned($random(seed)) % 4);
      v = $random(seed);
      wr_reg(`FPLL_ADDR_REFCTL, {14'h0, h[0], v[0], 6'h0, r[9:0]});
      span(1'b0, 1, c);
      span(1'b0, 4, c);
      chk("pfd", c, 4 * r * (1 + h));
    end
    wr_reg(`FPLL_ADDR_REFCTL, 32'h1);
    wr_reg(`FPLL_ADDR_INT, 32'h5);
    wr_reg(`FPLL_ADDR_AFRAC, 32'h0);
    wr_reg(`FPLL_ADDR_AMOD, 32'h3FFF);
    for (h = 0; h < 3; h++)
    begin
      // A full auxiliary fraction beside an all-ones primary fraction carries on every step.
      if (h == 2)
      begin
        wr_reg(`FPLL_ADDR_AFRAC, 32'h1);
        wr_reg(`FPLL_ADDR_AMOD, 32'h1);
      end
      wr_reg(`FPLL_ADDR_PFRAC, (h == 2) ? 32'hFFFFFF : {8'h0, h[0], 23'h0});
      span(1'b1, 2, c);
      span(1'b1, 8, c);
      chk("fb", c, 40 + 4 * h);
    end
    wr_reg(`FPLL_ADDR_TIMING, {8'h15, 10'h064, 5'h1A, 5'h0A, 4'h0});
    n_set = 0;
    n_band = 0;
    wr_reg(`FPLL_ADDR_CALCTL, 32'h1);
    wr_reg(`FPLL_ADDR_CALCTL, 32'h1);
    c = 0;
    while (done !== 1'b1)
    begin
      @(posedge clk_in);
      #1;
      c++;
      if (c > 8000)
      begin
        miscompares++;
        results();
      end
    end
    chk("settle", n_set, 100 * 10);
    chk("band", n_band, 11 * 16 * 21);
    rd_reg(`FPLL_ADDR_STATUS, 32'hFFFFFFFF, {28'h0, fpll_pkg::FPLL_DONE}, "status");
    results();
  end
endmodule
bind fpll_core fpll_core_props fpll_core_props_inst (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cal_busy_out(cal_busy_out),
  .band_sel_out(band_sel_out), .cal_done_out(cal_done_out));
`default_nettype wire
